// ===== rtl/radio_cmd_pkg.sv
// Package: command codes, register map, reset defaults and radio lookup figures
package radio_cmd_pkg;
  // Command bytes and the ready prompt
  localparam logic [7:0] CMD_CHANNEL  = 8'h43;
  localparam logic [7:0] CMD_POWER    = 8'h50;
  localparam logic [7:0] CMD_STRENGTH = 8'h53;
  localparam logic [7:0] CMD_TEMP     = 8'h55;
  localparam logic [7:0] CMD_VOLT     = 8'h56;
  localparam logic [7:0] CMD_EXIT     = 8'h58;
  localparam logic [7:0] PROMPT_CHAR  = 8'h3e;

  // Register word offsets (Avalon word address)
  localparam logic [1:0] REG_DEFAULTS = 2'h0;
  localparam logic [1:0] REG_CONTROL  = 2'h1;
  localparam logic [1:0] REG_STATUS   = 2'h2;
  localparam logic [1:0] REG_PACKET   = 2'h3;

  // Field positions
  localparam int F_CHANNEL = 0;   // 8 bits
  localparam int F_POWER   = 8;   // 3 bits
  localparam int F_RATE    = 12;  // 3 bits
  localparam int F_APPEND  = 16;  // 1 bit in defaults
  localparam int F_MODE    = 16;  // 3 bits in status
  localparam int F_RELOAD  = 0;   // control write strobe

  // Reset values of the stored defaults
  localparam logic [7:0] RST_CHANNEL = 8'h01;
  localparam logic [2:0] RST_POWER   = 3'h5;
  localparam logic [2:0] RST_RATE    = 3'h3;
  localparam logic       RST_APPEND  = 1'b0;

  // Power index and air rate code limits
  localparam logic [2:0] POWER_MAX = 3'h5;
  localparam logic [2:0] RATE_MAX  = 3'h6;

  // Carrier table figures in kHz
  localparam logic [19:0] F433_BASE = 20'h69bcc;
  localparam logic [19:0] F433_STEP = 20'h00064;
  localparam logic [19:0] F865_BASE = 20'hd334c;
  localparam logic [19:0] F865_STEP = 20'h000c8;
  localparam logic [19:0] F868_BASE = 20'hd3ed2;
  localparam logic [19:0] F868_C13  = 20'hd4495;
  localparam logic [19:0] F868_C14  = 20'hd4576;
  localparam logic [19:0] F868_C15  = 20'hd45da;
  localparam logic [19:0] F902_BASE = 20'hdc370;
  localparam logic [19:0] F902_STEP = 20'h001f4;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b000,
    MODE_PROMPT = 3'b001,
    MODE_CMD    = 3'b010,
    MODE_ARG    = 3'b011,
    MODE_RESULT = 3'b100
  } mode_e;
endpackage

// ===== rtl/radio_cmd.sv
// Radio setting and monitor query command interpreter with Avalon-MM slave
//
// The address map and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ns

module radio_cmd
  import radio_cmd_pkg::*;
#(
  parameter int unsigned VARIANT = 0  // 0:433, 1:865, 2:868, 3:902 band
) (
  input  wire logic        clk,              // System clock
  input  wire logic        rst_n,            // Async reset, active low
  input  wire logic [1:0]  avs_address,      // Word address
  input  wire logic        avs_read,         // Read request
  input  wire logic        avs_write,        // Write request
  input  wire logic [31:0] avs_writedata,    // Write data
  output logic      [31:0] avs_readdata,     // Read data
  output logic             avs_waitrequest,  // Stall
  input  wire logic        config_req_n,     // Command mode request, active low
  input  wire logic [7:0]  rx_data,          // Byte from host UART
  input  wire logic        rx_valid,         // One-cycle strobe with rx_data
  output logic      [7:0]  tx_data,          // Byte to host UART
  output logic             tx_valid,         // Byte offered
  input  wire logic        tx_ready,         // UART takes byte
  input  wire logic [7:0]  strength_in,      // Live signal strength code
  input  wire logic [7:0]  temp_in,          // Live temperature code
  input  wire logic [7:0]  volt_in,          // Live supply code
  input  wire logic        packet_end,       // Pulse at end of a received packet
  output logic      [7:0]  packet_strength,  // Strength captured for last packet
  output logic             append_strength,  // Append strength to received messages
  output logic      [7:0]  active_channel,   // Active channel index
  output logic      [2:0]  active_power,     // Active power index
  output logic      [2:0]  active_rate,      // Active air rate code
  output logic      [19:0] carrier_khz,      // Carrier frequency in kHz
  output logic      [7:0]  power_dbm,        // Nominal output level, signed dBm
  output logic      [16:0] rate_bps,         // Air rate in bit/s
  output logic             command_mode      // High outside normal operation
);

  localparam logic [7:0] NUM_CHANNELS = (VARIANT == 0) ? 8'h11 :
                                        (VARIANT == 3) ? 8'h32 : 8'h0f;

  // Refuse variants the tables do not cover
  if (VARIANT > 3) begin : bad_variant
    $error("VARIANT must be 0 to 3");
  end

  typedef struct packed {
    mode_e       mode;
    logic [7:0]  cmd;
    logic [7:0]  result;
    logic [7:0]  channel;
    logic [2:0]  power;
    logic [2:0]  rate;
    logic [7:0]  st_channel;
    logic [2:0]  st_power;
    logic [2:0]  st_rate;
    logic        st_append;
    logic        reload;
    logic        bus_ack;
    logic [31:0] rdata;
    logic [7:0]  tx_data;
    logic        tx_valid;
    logic [7:0]  pkt_strength;
    logic [19:0] freq;
    logic [7:0]  dbm;
    logic [16:0] bps;
  } state_s;

  state_s     q;
  state_s     next_q;
  logic [1:0] rst_pipe;
  logic       rst_sync_n;

  // Carrier frequency of a channel index for this variant
  function automatic logic [19:0] chan_freq(input logic [7:0] ch);
    logic [19:0] n;
    n = {12'h000, ch} - 20'h00001;
    unique case (VARIANT)
      0: chan_freq = 20'(F433_BASE + 20'(n * F433_STEP));
      1: chan_freq = 20'(F865_BASE + 20'(n * F865_STEP));
      2: begin
        if (ch == 8'h0d) chan_freq = F868_C13;
        else if (ch == 8'h0e) chan_freq = F868_C14;
        else if (ch == 8'h0f) chan_freq = F868_C15;
        else chan_freq = 20'(F868_BASE + 20'(n * F433_STEP));
      end
      default: chan_freq = 20'(F902_BASE + 20'({12'h000, ch} * F902_STEP));
    endcase
  endfunction

  // Nominal level of a power index, two's complement dBm
  function automatic logic [7:0] idx_dbm(input logic [2:0] p);
    unique case (p)
      3'h1: idx_dbm = 8'hec;
      3'h2: idx_dbm = 8'hf6;
      3'h3: idx_dbm = 8'h00;
      3'h4: idx_dbm = 8'h05;
      3'h5: idx_dbm = (VARIANT == 2) ? 8'h09 : 8'h0a;
      default: idx_dbm = 8'h00;
    endcase
  endfunction

  // Bit rate of an air rate code; reserved codes give zero
  function automatic logic [16:0] code_bps(input logic [2:0] r);
    unique case (r)
      3'h1: code_bps = 17'h004b0;
      3'h2: code_bps = 17'h012c0;
      3'h3: code_bps = 17'h04a38;
      3'h4: code_bps = 17'h08000;
      3'h5: code_bps = 17'h12c00;
      3'h6: code_bps = 17'h186a0;
      default: code_bps = 17'h00000;
    endcase
  endfunction

  function automatic logic chan_ok(input logic [7:0] ch);
    chan_ok = (ch != 8'h00) && (ch <= NUM_CHANNELS);
  endfunction

  function automatic logic power_ok(input logic [2:0] p);
    power_ok = (p != 3'h0) && (p <= POWER_MAX);
  endfunction

  // Reset release through two flops; the first is read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rst_pipe <= 2'b00;
    else rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_sync_n = rst_pipe[1];

  logic bus_req;
  logic bus_go;
  assign bus_req = avs_read | avs_write;
  assign bus_go  = bus_req & q.bus_ack;

  // Next-state logic for bus, command sequencer and radio settings
  always_comb begin
    next_q = q;
    // One wait cycle per access; read data is latched during the wait
    next_q.bus_ack = bus_req & ~q.bus_ack;
    if (bus_req && !q.bus_ack) begin
      unique case (avs_address)
        REG_DEFAULTS: next_q.rdata = 32'({q.st_append, 1'b0, q.st_rate, 1'b0,
                                          q.st_power, q.st_channel});
        REG_STATUS:   next_q.rdata = 32'({q.mode, 1'b0, q.rate, 1'b0, q.power, q.channel});
        REG_PACKET:   next_q.rdata = 32'(q.pkt_strength);
        default:      next_q.rdata = 32'h00000000;
      endcase
    end
    // Bus writes touch the stored set and the reload flag only; commands never do
    if (bus_go && avs_write) begin
      if (avs_address == REG_DEFAULTS) begin
        next_q.st_channel = avs_writedata[F_CHANNEL +: 8];
        next_q.st_power   = avs_writedata[F_POWER +: 3];
        next_q.st_rate    = avs_writedata[F_RATE +: 3];
        next_q.st_append  = avs_writedata[F_APPEND];
      end
      if (avs_address == REG_CONTROL && avs_writedata[F_RELOAD]) next_q.reload = 1'b1;
    end
    // Load active set from the stored set; invalid stored values keep the old one
    if (q.reload) begin
      next_q.reload = 1'b0;
      if (chan_ok(q.st_channel)) next_q.channel = q.st_channel;
      if (power_ok(q.st_power)) next_q.power = q.st_power;
      if (q.st_rate != 3'h0 && q.st_rate <= RATE_MAX) next_q.rate = q.st_rate;
    end
    // Packet strength is caught at packet end when appending is on
    if (packet_end && q.st_append) next_q.pkt_strength = strength_in;
    // Registered lookups of the active settings
    next_q.freq = chan_freq(q.channel);
    next_q.dbm  = idx_dbm(q.power);
    next_q.bps  = code_bps(q.rate);
    // Command sequencer; rx bytes outside CMD and ARG are ignored
    unique case (q.mode)
      MODE_NORMAL: begin
        if (!config_req_n) next_q.mode = MODE_PROMPT;
      end
      MODE_PROMPT, MODE_RESULT: begin
        if (q.tx_valid && tx_ready) begin
          next_q.tx_valid = 1'b0;
          // Prompt follows the result byte directly
          next_q.mode = (q.mode == MODE_RESULT) ? MODE_PROMPT : MODE_CMD;
        end else if (!q.tx_valid) begin
          next_q.tx_valid = 1'b1;
          next_q.tx_data  = (q.mode == MODE_RESULT) ? q.result : PROMPT_CHAR;
        end
      end
      MODE_CMD: begin
        if (rx_valid) begin
          next_q.cmd  = rx_data;
          next_q.mode = MODE_PROMPT;  // Unknown codes are dropped and reprompted
          unique case (rx_data)
            CMD_CHANNEL, CMD_POWER: next_q.mode = MODE_ARG;
            CMD_STRENGTH: begin
              next_q.result = strength_in;
              next_q.mode   = MODE_RESULT;
            end
            CMD_TEMP: begin
              next_q.result = temp_in;
              next_q.mode   = MODE_RESULT;
            end
            CMD_VOLT: begin
              next_q.result = volt_in;
              next_q.mode   = MODE_RESULT;
            end
            // Exit only once the request pin is released; no prompt after it
            CMD_EXIT: if (config_req_n) next_q.mode = MODE_NORMAL;
            default: next_q.mode = MODE_PROMPT;
          endcase
        end
      end
      MODE_ARG: begin
        if (rx_valid) begin
          // Out-of-range arguments are dropped but still reprompted
          if (q.cmd == CMD_CHANNEL && chan_ok(rx_data)) next_q.channel = rx_data;
          if (q.cmd == CMD_POWER && rx_data[7:3] == 5'h00 && power_ok(rx_data[2:0]))
            next_q.power = rx_data[2:0];
          next_q.mode = MODE_PROMPT;
        end
      end
      default: next_q.mode = MODE_NORMAL;
    endcase
  end

  // State register; reset values equal the stored defaults, and a reload follows release
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      q            <= '0;
      q.mode       <= MODE_NORMAL;
      q.channel    <= RST_CHANNEL;
      q.power      <= RST_POWER;
      q.rate       <= RST_RATE;
      q.st_channel <= RST_CHANNEL;
      q.st_power   <= RST_POWER;
      q.st_rate    <= RST_RATE;
      q.st_append  <= RST_APPEND;
      q.reload     <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // Outputs
  assign avs_waitrequest = bus_req & ~q.bus_ack;
  assign avs_readdata    = q.rdata;
  assign tx_data         = q.tx_data;
  assign tx_valid        = q.tx_valid;
  assign packet_strength = q.pkt_strength;
  assign append_strength = q.st_append;
  assign active_channel  = q.channel;
  assign active_power    = q.power;
  assign active_rate     = q.rate;
  assign carrier_khz     = q.freq;
  assign power_dbm       = q.dbm;
  assign rate_bps        = q.bps;
  assign command_mode    = (q.mode != MODE_NORMAL);

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  sequence result_then_prompt;
    (q.mode == MODE_RESULT && tx_valid && tx_ready) ##1 (q.mode == MODE_PROMPT && !tx_valid)
      ##1 (tx_valid && tx_data == PROMPT_CHAR);
  endsequence

  enter_prompt_a: assert property (q.mode == MODE_NORMAL && !config_req_n |=> ##1
    (tx_valid && tx_data == PROMPT_CHAR)) else $error("no prompt on entry");
  result_prompt_a: assert property (q.mode == MODE_RESULT && tx_valid && tx_ready
    |-> result_then_prompt) else $error("result not followed by prompt");
  strength_byte_a: assert property (q.mode == MODE_CMD && rx_valid && rx_data == CMD_STRENGTH
    |=> ##1 (tx_valid && tx_data == $past(strength_in, 2))) else $error("bad strength byte");
  temp_byte_a: assert property (q.mode == MODE_CMD && rx_valid && rx_data == CMD_TEMP
    |=> ##1 (tx_valid && tx_data == $past(temp_in, 2))) else $error("bad temperature byte");
  volt_byte_a: assert property (q.mode == MODE_CMD && rx_valid && rx_data == CMD_VOLT
    |=> ##1 (tx_valid && tx_data == $past(volt_in, 2))) else $error("bad supply byte");
  channel_cmd_a: assert property (q.mode == MODE_ARG && q.cmd == CMD_CHANNEL && rx_valid
    && chan_ok(rx_data) |=> active_channel == $past(rx_data)) else $error("channel not applied");
  stored_kept_a: assert property (!(bus_go && avs_write) |=> $stable(q.st_channel)
    && $stable(q.st_power) && $stable(q.st_rate)) else $error("stored default changed");
  reload_load_a: assert property (q.reload && chan_ok(q.st_channel)
    |=> active_channel == $past(q.st_channel)) else $error("default channel not loaded");
  rate_source_a: assert property ($changed(active_rate) |-> $past(q.reload))
    else $error("rate changed without reload");
  freq_map_a: assert property ($changed(active_channel) |=>
    carrier_khz == chan_freq($past(active_channel))) else $error("carrier mismatch");
  power_map_a: assert property ($changed(active_power) |=>
    power_dbm == idx_dbm($past(active_power))) else $error("power level mismatch");
  packet_rssi_a: assert property (packet_end && append_strength
    |=> packet_strength == $past(strength_in)) else $error("packet strength not captured");

endmodule // radio_cmd

// ===== verif/host_uart_model.sv
// Host controller model on the command link: sends bytes and collects replies
`timescale 1ns/1ns
module host_uart_model (
  input  wire logic       clk,       // System clock
  input  wire logic       rst_n,     // Reset, active low
  input  wire logic       slow,      // Stall the reply link
  input  wire logic [7:0] tx_data,   // Byte from device
  input  wire logic       tx_valid,  // Byte offered by device
  output logic            tx_ready,  // Byte taken by host
  output logic      [7:0] rx_data,   // Byte to device
  output logic            rx_valid   // Strobe with rx_data
);
  logic [7:0] got [$];   // Accepted reply bytes, oldest first
  logic [1:0] stall_cnt; // Paces ready while slow

  // Quiet link at time zero
  initial begin
    rx_data   = 8'h00;
    rx_valid  = 1'b0;
  end

  // Take replies; when slow only every fourth cycle, so the device must hold its byte
  always @(posedge clk) begin
    if (!rst_n) begin
      stall_cnt <= 2'h0;
      tx_ready  <= 1'b0;
      got.delete();
    end else begin
      stall_cnt <= stall_cnt + 2'h1;
      tx_ready  <= !slow || (stall_cnt == 2'h3);
      if (tx_valid && tx_ready) got.push_back(tx_data);
    end
  end

  // One byte per call; afterwards the line shows the inverse so a stale byte never looks valid
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    rx_data  <= b;
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data  <= ~b;
  endtask
endmodule // host_uart_model

// ===== verif/tb_radio_setting_and_monitor_query.sv
// Testbench for the radio setting and monitor query block
`timescale 1ns/1ns
module tb_radio_setting_and_monitor_query;
  import radio_cmd_pkg::*;
  logic        clk, rst_n, avs_read, avs_write, avs_waitrequest, config_req_n;
  logic        rx_valid, tx_valid, tx_ready, packet_end, append_strength, command_mode, slow;
  logic [1:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0]  rx_data, tx_data, strength_in, temp_in, volt_in, packet_strength;
  logic [7:0]  active_channel, power_dbm;
  logic [2:0]  active_power, active_rate;
  logic [19:0] carrier_khz;
  logic [16:0] rate_bps;
  int          miscompares, num_checks;
  logic [7:0]  qcode [3] = '{CMD_STRENGTH, CMD_TEMP, CMD_VOLT};
  logic [7:0]  qval  [3] = '{8'h5a, 8'h98, 8'h68};
  logic [7:0]  scode [4] = '{CMD_CHANNEL, CMD_CHANNEL, CMD_POWER, CMD_CHANNEL};
  logic [7:0]  sarg  [4] = '{8'h03, 8'h12, 8'h02, 8'h11};
  logic [7:0]  ech   [4] = '{8'h03, 8'h03, 8'h03, 8'h11};
  logic [2:0]  epw   [4] = '{3'h5, 3'h5, 3'h2, 3'h2};

  radio_cmd #(.VARIANT(0)) radio_cmd_i (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .config_req_n(config_req_n), .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .strength_in(strength_in), .temp_in(temp_in),
    .volt_in(volt_in), .packet_end(packet_end), .packet_strength(packet_strength),
    .append_strength(append_strength), .active_channel(active_channel),
    .active_power(active_power), .active_rate(active_rate), .carrier_khz(carrier_khz),
    .power_dbm(power_dbm), .rate_bps(rate_bps), .command_mode(command_mode));

  host_uart_model host_uart_model_i (.clk(clk), .rst_n(rst_n), .slow(slow), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid));

  // Free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Verdict and the single end of the run
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // A wait that ran out counts as a mismatch
  task automatic give_up;
    miscompares++;
    $display("timeout at %0t", $time);
    end_of_test();
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus access; request held until a rising edge samples waitrequest low
  task automatic bus(input logic [1:0] a, input logic [31:0] d, input logic wr);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) give_up();
    // Read data is taken at the accepting edge, then the request is released
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic rd_chk(input logic [1:0] a, input logic [31:0] exp);
    bus(a, 32'h0000_0000, 1'b0);
    check(rd, exp);
  endtask

  // Next reply byte from the host model, bounded wait
  task automatic get_byte(input logic [7:0] exp);
    int n;
    n = 0;
    while (host_uart_model_i.got.size() == 0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (host_uart_model_i.got.size() == 0) give_up();
    check({24'h0, host_uart_model_i.got.pop_front()}, {24'h0, exp});
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 2'h0;
    avs_writedata = 32'h0;
    config_req_n = 1'b1;
    strength_in = 8'h5a;
    temp_in = 8'h98;
    volt_in = 8'h68;
    packet_end = 1'b0;
    slow = 1'b0;
    miscompares = 0;
    num_checks = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(REG_DEFAULTS, 32'h0000_3501);
    rd_chk(REG_STATUS, 32'h0000_3501);
    check({12'h0, carrier_khz}, {12'h0, F433_BASE});
    check({24'h0, power_dbm}, 32'h0000_000a);
    check({15'h0, rate_bps}, 32'h0000_4a38);
    // Enter command mode; the host talks only after the first prompt
    config_req_n <= 1'b0;
    get_byte(PROMPT_CHAR);
    check({31'h0, command_mode}, 32'h1);
    config_req_n <= 1'b1;
    // Three queries, the middle one against a stalling host
    for (int i = 0; i < 3; i++) begin
      slow <= (i == 1);
      host_uart_model_i.send(qcode[i]);
      get_byte(qval[i]);
      get_byte(PROMPT_CHAR);
    end
    // Channel and power commands; out-of-range channel dropped; channel 17 legal on 433
    for (int i = 0; i < 4; i++) begin
      host_uart_model_i.send(scode[i]);
      host_uart_model_i.send(sarg[i]);
      get_byte(PROMPT_CHAR);
      check({24'h0, active_channel}, {24'h0, ech[i]});
      check({29'h0, active_power}, {29'h0, epw[i]});
      check({12'h0, carrier_khz}, {12'h0, F433_BASE + F433_STEP * 20'(ech[i] - 8'h01)});
    end
    check({24'h0, power_dbm}, 32'h0000_00f6);
    rd_chk(REG_DEFAULTS, 32'h0000_3501);
    rd_chk(REG_STATUS, 32'h0002_3211);
    // Unknown code is answered with a fresh prompt
    host_uart_model_i.send(8'h41);
    get_byte(PROMPT_CHAR);
    // Exit while the request pin is still low is refused and reprompted
    config_req_n <= 1'b0;
    host_uart_model_i.send(CMD_EXIT);
    get_byte(PROMPT_CHAR);
    config_req_n <= 1'b1;
    // Exit gives no prompt and leaves command mode
    host_uart_model_i.send(CMD_EXIT);
    repeat (20) @(posedge clk);
    check({31'h0, command_mode}, 32'h0);
    check(host_uart_model_i.got.size(), 32'h0);
    check({24'h0, active_channel}, 32'h0000_0011);
    // New stored set; active values move only on reload
    bus(REG_DEFAULTS, 32'h0001_1405, 1'b1);
    rd_chk(REG_DEFAULTS, 32'h0001_1405);
    check({29'h0, active_rate}, 32'h3);
    check({31'h0, append_strength}, 32'h1);
    bus(REG_CONTROL, 32'h0000_0001, 1'b1);
    repeat (3) @(posedge clk);
    check({24'h0, active_channel}, 32'h5);
    check({15'h0, rate_bps}, 32'h0000_04b0);
    check({24'h0, power_dbm}, 32'h0000_0005);
    // Reserved rate code never loads; status ignores writes
    bus(REG_DEFAULTS, 32'h0001_7405, 1'b1);
    bus(REG_CONTROL, 32'h0000_0001, 1'b1);
    bus(REG_STATUS, 32'hffff_ffff, 1'b1);
    rd_chk(REG_STATUS, 32'h0000_1405);
    // Per-packet strength with append set
    strength_in <= 8'h40;
    packet_end <= 1'b1;
    @(posedge clk);
    packet_end <= 1'b0;
    @(posedge clk);
    check({24'h0, packet_strength}, 32'h40);
    rd_chk(REG_PACKET, 32'h0000_0040);
    // Second reset in mid-run restores defaults and drops reloaded values
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(REG_STATUS, 32'h0000_3501);
    end_of_test();
  end
endmodule // tb_radio_setting_and_monitor_query
